// *** shared/usb_dev_regs_pkg.sv ***
// constants, register map and types for the usb device state and irq registers
package usb_dev_regs_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] FRAME_NUMBER_ADDR = 32'hFFFA4000;
  localparam logic [31:0] GLOBAL_DEVICE_STATE_ADDR = 32'hFFFA4004;
  localparam logic [31:0] FUNCTION_ADDRESS_ADDR = 32'hFFFA4008;
  localparam logic [31:0] IRQ_ENABLE_SET_ADDR = 32'hFFFA4010;
  localparam logic [31:0] IRQ_ENABLE_CLEAR_ADDR = 32'hFFFA4014;
  localparam logic [31:0] IRQ_MASK_VIEW_ADDR = 32'hFFFA4018;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int FRAME_W = 11;
  localparam int SOF_ERROR_POS = 16;
  localparam int SOF_GOOD_POS = 17;
  localparam int ADDRESSED_POS = 0;
  localparam int CONFIGURED_POS = 1;
  localparam int FUNC_ADDR_W = 7;
  localparam int FUNC_EN_POS = 8;
  localparam int IRQ_W = 14;
  localparam int SUSPEND_POS = 8;
  localparam int RESUME_POS = 9;
  localparam int FRAME_START_POS = 11;
  localparam int UNMASKABLE_POS = 12;
  localparam int WAKEUP_POS = 13;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [IRQ_W-1:0] MASK_WRITABLE = 14'h2B3F;
  localparam logic [IRQ_W-1:0] MASK_RESET = 14'h0200;
  localparam logic [IRQ_W-1:0] MASK_FORCED = 14'h1000;
  localparam logic [FRAME_W-1:0] FRAME_RESET = 11'h000;
  localparam logic [FUNC_ADDR_W-1:0] FUNC_ADDR_RESET = 7'h00;
  localparam logic FUNC_EN_RESET = 1'b1;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

  // ----------------------------------------------------------------
  // bus slave handshake states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

endpackage : usb_dev_regs_pkg

// *** shared/sof_capture_if.sv ***
// interface carrying captured start-of-frame state to the register block
`timescale 1ns/10ps
interface sof_capture_if;
  import usb_dev_regs_pkg::*;

  logic [FRAME_W-1:0] frame_counter_field;
  logic sof_good_flag;
  logic sof_error_flag;
  logic frame_start_pulse;

  modport capture (
    output frame_counter_field,
    output sof_good_flag,
    output sof_error_flag,
    output frame_start_pulse
  );

  modport regs (
    input frame_counter_field,
    input sof_good_flag,
    input sof_error_flag,
    input frame_start_pulse
  );
endinterface : sof_capture_if

// *** verilog/sof_frame_capture.sv ***
// start-of-frame capture: frame number and good/error flags
`timescale 1ns/10ps
module sof_frame_capture
  import usb_dev_regs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sof_pid_seen,
  input wire logic sof_eop,
  input wire logic sof_packet_error,
  input wire logic [usb_dev_regs_pkg::FRAME_W-1:0] frame_field_in,
  sof_capture_if.capture cap
);

  // ----------------------------------------------------------------
  // frame number
  // ----------------------------------------------------------------
  // the packet decoder presents the field together with the eop strobe
  always_ff @(posedge clk)
  begin
    if (srst)
      cap.frame_counter_field <= FRAME_RESET;
    else if (sof_eop)
      cap.frame_counter_field <= frame_field_in;
  end

  // ----------------------------------------------------------------
  // frame flags
  // ----------------------------------------------------------------
  // set wins over clear so a coincident eop is never lost
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cap.sof_good_flag <= 1'b0;
      cap.sof_error_flag <= 1'b0;
    end
    else if (sof_eop)
    begin
      cap.sof_error_flag <= sof_packet_error;
      cap.sof_good_flag <= ~sof_packet_error;
    end
    else if (sof_pid_seen)
    begin
      cap.sof_good_flag <= 1'b0;
      cap.sof_error_flag <= 1'b0;
    end
  end

  // frame start event fires on the pid, not on the eop
  always_ff @(posedge clk)
  begin
    if (srst)
      cap.frame_start_pulse <= 1'b0;
    else
      cap.frame_start_pulse <= sof_pid_seen;
  end

endmodule : sof_frame_capture

// *** verilog/usb_device_state_and_irq_regs.sv ***
// usb device state, function address and interrupt mask registers
`timescale 1ns/10ps

// Summary of operation
// - latch 11-bit frame number at sof eop
// - set frame error flag at bad sof
// - set frame good flag at clean sof
// - clear both frame flags on sof pid
// - raise frame start status on sof pid
// - addressed bit sets on 1, write 0 ignored
// - configured bit follows written value
// - 7-bit function address, zero after reset
// - function enable bit, one after reset, passed out to endpoint logic
// - enable register writes set mask bits
// - disable register writes clear mask bits
// - mask view shows enabled sources
// - mask bit 12 always reads one
// - interrupt only when flag and mask set
// - bus reset end restores mask reset value
module usb_device_state_and_irq_regs
  import usb_dev_regs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [usb_dev_regs_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [usb_dev_regs_pkg::BE_W-1:0] byteenable,
  input wire logic [usb_dev_regs_pkg::DATA_W-1:0] writedata,
  output logic [usb_dev_regs_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // packet decoder side
  input wire logic sof_pid_seen,
  input wire logic sof_eop,
  input wire logic sof_packet_error,
  input wire logic [usb_dev_regs_pkg::FRAME_W-1:0] frame_field_in,
  input wire logic bus_reset_end,
  input wire logic [usb_dev_regs_pkg::IRQ_W-1:0] irq_status,
  // device state towards endpoint logic
  output logic frame_start_irq,
  output logic addressed_state_bit,
  output logic configured_state_bit,
  output logic [usb_dev_regs_pkg::FUNC_ADDR_W-1:0] function_addr_value,
  output logic function_enable_bit,
  output logic [usb_dev_regs_pkg::IRQ_W-1:0] irq_mask,
  output logic irq
);
  import usb_dev_regs_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sof_capture_if sof_bus ();

  bus_state_t bus_state_reg;
  bus_state_t bus_state_next;
  logic [DATA_W-1:0] readdata_reg;
  logic [DATA_W-1:0] readdata_next;
  logic addressed_reg;
  logic configured_reg;
  logic [FUNC_ADDR_W-1:0] func_addr_reg;
  logic func_en_reg;
  logic [IRQ_W-1:0] mask_reg;
  logic [IRQ_W-1:0] mask_next;
  logic irq_reg;
  logic frame_start_reg;
  logic req;
  logic do_write;
  logic [DATA_W-1:0] be_bits;
  logic [DATA_W-1:0] wr_bits;
  logic [IRQ_W-1:0] set_bits;
  logic [IRQ_W-1:0] clr_bits;
  logic [IRQ_W-1:0] mask_view;

  // ----------------------------------------------------------------
  // start-of-frame capture
  // ----------------------------------------------------------------
  sof_frame_capture u_sof_capture (
    .clk(clk),
    .srst(srst),
    .sof_pid_seen(sof_pid_seen),
    .sof_eop(sof_eop),
    .sof_packet_error(sof_packet_error),
    .frame_field_in(frame_field_in),
    .cap(sof_bus.capture)
  );

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // a request is seen in one cycle and answered in the next, one wait
  // state; the master holds the request until waitrequest drops
  assign req = read | write;

  // write takes effect only at the edge where waitrequest is low
  assign do_write = write & (bus_state_reg == BUS_ACK);

  // expand byte enables to a bit mask, lanes not enabled keep old data
  always_comb
  begin
    be_bits = {{8{byteenable[3]}}, {8{byteenable[2]}},
               {8{byteenable[1]}}, {8{byteenable[0]}}};
    wr_bits = writedata & be_bits;
  end

  // answer state
  always_comb
  begin
    bus_state_next = BUS_IDLE;
    case (bus_state_reg)
      BUS_IDLE:
      begin
        if (req)
          bus_state_next = BUS_ACK;
      end
      BUS_ACK:
      begin
        bus_state_next = BUS_IDLE;
      end
      default:
      begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      bus_state_reg <= BUS_IDLE;
    else
      bus_state_reg <= bus_state_next;
  end

  // waitrequest is registered; idle high so nothing is taken by surprise
  always_ff @(posedge clk)
  begin
    if (srst)
      waitrequest <= 1'b1;
    else
      waitrequest <= ~(bus_state_next == BUS_ACK);
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // mask view forces the unmaskable bit whatever was written
  assign mask_view = mask_reg | MASK_FORCED;

  // write-only and unmapped addresses read as zero
  always_comb
  begin
    readdata_next = READ_ZERO;
    case (address)
      FRAME_NUMBER_ADDR:
      begin
        readdata_next[FRAME_W-1:0] = sof_bus.frame_counter_field;
        readdata_next[SOF_ERROR_POS] = sof_bus.sof_error_flag;
        readdata_next[SOF_GOOD_POS] = sof_bus.sof_good_flag;
      end
      GLOBAL_DEVICE_STATE_ADDR:
      begin
        readdata_next[ADDRESSED_POS] = addressed_reg;
        readdata_next[CONFIGURED_POS] = configured_reg;
      end
      FUNCTION_ADDRESS_ADDR:
      begin
        readdata_next[FUNC_ADDR_W-1:0] = func_addr_reg;
        readdata_next[FUNC_EN_POS] = func_en_reg;
      end
      IRQ_MASK_VIEW_ADDR:
      begin
        readdata_next[IRQ_W-1:0] = mask_view;
      end
      default:
      begin
        readdata_next = READ_ZERO;
      end
    endcase
  end

  // data captured with the request so it stands while waitrequest is low
  always_ff @(posedge clk)
  begin
    if (srst)
      readdata_reg <= READ_ZERO;
    else if (read & (bus_state_reg == BUS_IDLE))
      readdata_reg <= readdata_next;
    else if (bus_state_reg == BUS_ACK)
      readdata_reg <= READ_ZERO;
  end

  assign readdata = readdata_reg;

  // ----------------------------------------------------------------
  // global device state
  // ----------------------------------------------------------------
  // only a reset leaves the addressed state; a usb bus reset returns the
  // device to default, so the end-of-reset event clears it too
  always_ff @(posedge clk)
  begin
    if (srst)
      addressed_reg <= 1'b0;
    else if (bus_reset_end)
      addressed_reg <= 1'b0;
    else if (do_write && address == GLOBAL_DEVICE_STATE_ADDR &&
             wr_bits[ADDRESSED_POS])
      addressed_reg <= 1'b1;
  end

  // configured follows the written value when its lane is enabled
  always_ff @(posedge clk)
  begin
    if (srst)
      configured_reg <= 1'b0;
    else if (bus_reset_end)
      configured_reg <= 1'b0;
    else if (do_write && address == GLOBAL_DEVICE_STATE_ADDR &&
             byteenable[0])
      configured_reg <= writedata[CONFIGURED_POS];
  end

  // ----------------------------------------------------------------
  // function address
  // ----------------------------------------------------------------
  // hardware does not check ordering against the status stage; software
  // must load the address before raising the addressed bit
  always_ff @(posedge clk)
  begin
    if (srst)
      func_addr_reg <= FUNC_ADDR_RESET;
    else if (do_write && address == FUNCTION_ADDRESS_ADDR && byteenable[0])
      func_addr_reg <= writedata[FUNC_ADDR_W-1:0];
  end

  // enable lives in byte lane one; reset value is enabled
  always_ff @(posedge clk)
  begin
    if (srst)
      func_en_reg <= FUNC_EN_RESET;
    else if (do_write && address == FUNCTION_ADDRESS_ADDR && byteenable[1])
      func_en_reg <= writedata[FUNC_EN_POS];
  end

  // ----------------------------------------------------------------
  // interrupt mask
  // ----------------------------------------------------------------
  // only documented source bits are writable; others are dropped
  always_comb
  begin
    set_bits = '0;
    clr_bits = '0;
    if (do_write && address == IRQ_ENABLE_SET_ADDR)
      set_bits = wr_bits[IRQ_W-1:0] & MASK_WRITABLE;
    if (do_write && address == IRQ_ENABLE_CLEAR_ADDR)
      clr_bits = wr_bits[IRQ_W-1:0] & MASK_WRITABLE;
    mask_next = (mask_reg & ~clr_bits) | set_bits;
  end

  // the usb reset event outranks a software write in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      mask_reg <= MASK_RESET;
    else if (bus_reset_end)
      mask_reg <= MASK_RESET;
    else
      mask_reg <= mask_next & MASK_WRITABLE;
  end

  // ----------------------------------------------------------------
  // interrupt request and state outputs
  // ----------------------------------------------------------------
  // registered so the line is glitch free; costs one cycle of latency
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(irq_status & mask_view);
  end

  // frame start event passed on for the status register
  always_ff @(posedge clk)
  begin
    if (srst)
      frame_start_reg <= 1'b0;
    else
      frame_start_reg <= sof_bus.frame_start_pulse;
  end

  assign irq = irq_reg;
  assign frame_start_irq = frame_start_reg;
  assign addressed_state_bit = addressed_reg;
  assign configured_state_bit = configured_reg;
  assign function_addr_value = func_addr_reg;
  assign function_enable_bit = func_en_reg;
  assign irq_mask = mask_view;

endmodule : usb_device_state_and_irq_regs

// *** tb/usb_regs_chk.sv ***
// assertions on the ports of the usb device register block
`timescale 1ns/10ps
module usb_regs_chk
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [usb_dev_regs_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [usb_dev_regs_pkg::BE_W-1:0] byteenable,
  input wire logic [usb_dev_regs_pkg::DATA_W-1:0] writedata,
  input wire logic waitrequest,
  input wire logic [usb_dev_regs_pkg::DATA_W-1:0] readdata,
  input wire logic sof_pid_seen,
  input wire logic bus_reset_end,
  input wire logic [usb_dev_regs_pkg::IRQ_W-1:0] irq_status,
  input wire logic frame_start_irq,
  input wire logic addressed_state_bit,
  input wire logic configured_state_bit,
  input wire logic [usb_dev_regs_pkg::FUNC_ADDR_W-1:0] function_addr_value,
  input wire logic [usb_dev_regs_pkg::IRQ_W-1:0] irq_mask,
  input wire logic irq
);
  import usb_dev_regs_pkg::*;
  logic wr_done;
  logic [IRQ_W-1:0] wr_bits;
  // a bus reset end in the same cycle wins, so such writes are left out
  assign wr_done = write && !waitrequest && !bus_reset_end;
  assign wr_bits = writedata[IRQ_W-1:0] & MASK_WRITABLE;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ----
  // steps of the handshake and of the frame start pulse
  // ----
  sequence one_wait_s;
    !waitrequest ##1 waitrequest;
  endsequence
  sequence sof_pulse_s;
    1'b1 ##2 frame_start_irq;
  endsequence
  bus_wait_a:
    assert property ((read || write) && waitrequest |=> one_wait_s)
    else $error("bus answer not a single wait state");
  sof_irq_a:
    assert property (sof_pid_seen |-> sof_pulse_s)
    else $error("frame start irq missing after pid");
  sof_src_a:
    assert property (frame_start_irq |-> $past(sof_pid_seen, 2))
    else $error("frame start irq without pid");
  rdata_idle_a:
    assert property (waitrequest |-> readdata == '0)
    else $error("read data not zero outside the answer cycle");
  bit_twelve_a:
    assert property (irq_mask[UNMASKABLE_POS])
    else $error("mask bit 12 reads zero");
  irq_gate_a:
    assert property (!$past(srst) |-> irq == |($past(irq_status) & $past(irq_mask)))
    else $error("irq does not follow status and mask");
  addr_set_a:
    assert property (wr_done && address == GLOBAL_DEVICE_STATE_ADDR && byteenable[0]
      && writedata[ADDRESSED_POS] |=> addressed_state_bit)
    else $error("addressed bit not set by write");
  addr_hold_a:
    assert property (addressed_state_bit && !bus_reset_end |=> addressed_state_bit)
    else $error("addressed bit dropped");
  config_wr_a:
    assert property (wr_done && address == GLOBAL_DEVICE_STATE_ADDR && byteenable[0]
      |=> configured_state_bit == $past(writedata[CONFIGURED_POS]))
    else $error("configured bit not as written");
  faddr_wr_a:
    assert property (wr_done && address == FUNCTION_ADDRESS_ADDR && byteenable[0]
      |=> function_addr_value == $past(writedata[FUNC_ADDR_W-1:0]))
    else $error("function address not as written");
  mask_set_a:
    assert property (wr_done && address == IRQ_ENABLE_SET_ADDR && byteenable == 4'hF
      |=> (irq_mask & $past(wr_bits)) == $past(wr_bits))
    else $error("enable write did not set mask");
  mask_clr_a:
    assert property (wr_done && address == IRQ_ENABLE_CLEAR_ADDR && byteenable == 4'hF
      |=> (irq_mask & $past(wr_bits)) == '0)
    else $error("disable write did not clear mask");
  mask_rst_a:
    assert property (bus_reset_end |=> irq_mask == (MASK_RESET | MASK_FORCED))
    else $error("mask not restored by bus reset end");
endmodule : usb_regs_chk

bind usb_device_state_and_irq_regs usb_regs_chk chk (
  .clk, .srst, .address, .read, .write, .byteenable, .writedata, .waitrequest, .readdata,
  .sof_pid_seen, .bus_reset_end, .irq_status, .frame_start_irq, .addressed_state_bit,
  .configured_state_bit, .function_addr_value, .irq_mask, .irq
);

// *** tb/usb_host_model.sv ***
// behavioural host side: start-of-frame packets and bus reset end events
`timescale 1ns/10ps
module usb_host_model
(
  input wire logic clk,
  output logic sof_pid_seen,
  output logic sof_eop,
  output logic sof_packet_error,
  output logic [usb_dev_regs_pkg::FRAME_W-1:0] frame_field_in,
  output logic bus_reset_end
);
  import usb_dev_regs_pkg::*;
  // lines idle with junk so a stale frame field is never mistaken for a fresh one
  initial
  begin
    sof_pid_seen = 1'b0;
    sof_eop = 1'b0;
    sof_packet_error = 1'b1;
    frame_field_in = 11'h2AA;
    bus_reset_end = 1'b0;
  end
  task automatic send_pid();
    @(posedge clk);
    sof_pid_seen <= 1'b1;
    @(posedge clk);
    sof_pid_seen <= 1'b0;
  endtask : send_pid
  // gap sets how slowly the end of packet follows the pid
  task automatic send_sof(input logic [FRAME_W-1:0] frame, input logic bad, input int gap);
    send_pid();
    repeat (gap) @(posedge clk);
    sof_eop <= 1'b1;
    frame_field_in <= frame;
    sof_packet_error <= bad;
    @(posedge clk);
    sof_eop <= 1'b0;
    frame_field_in <= ~frame;
    sof_packet_error <= ~bad;
  endtask : send_sof
  task automatic bus_reset();
    @(posedge clk);
    bus_reset_end <= 1'b1;
    @(posedge clk);
    bus_reset_end <= 1'b0;
  endtask : bus_reset
endmodule : usb_host_model

// *** tb/usb_device_state_and_irq_regs_tb.sv ***
// self-checking bench for the usb device state and irq register block
`timescale 1ns/10ps
module usb_device_state_and_irq_regs_tb;
  import usb_dev_regs_pkg::*;
  logic clk, srst, read, write, waitrequest, irq, frame_start_irq;
  logic sof_pid_seen, sof_eop, sof_packet_error, bus_reset_end;
  logic addressed_state_bit, configured_state_bit, function_enable_bit;
  logic [ADDR_W-1:0] address;
  logic [BE_W-1:0] byteenable;
  logic [DATA_W-1:0] writedata, readdata, rd, exp;
  logic [FRAME_W-1:0] frame_field_in;
  logic [IRQ_W-1:0] irq_status, irq_mask;
  logic [FUNC_ADDR_W-1:0] function_addr_value;
  int fail_count, num_checks, b;
  usb_host_model host (.clk, .sof_pid_seen, .sof_eop, .sof_packet_error, .frame_field_in,
    .bus_reset_end);
  usb_device_state_and_irq_regs dut (.clk, .srst, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .sof_pid_seen, .sof_eop, .sof_packet_error,
    .frame_field_in, .bus_reset_end, .irq_status, .frame_start_irq, .addressed_state_bit,
    .configured_state_bit, .function_addr_value, .function_enable_bit, .irq_mask, .irq);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    num_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check
  // request held until waitrequest is seen low; data taken at that edge
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be, output logic [DATA_W-1:0] q);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (!waitrequest)
        break;
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n == 50)
    begin
      fail_count++;
      $display("unexpected at %0t: no bus answer", $time);
      print_verdict();
    end
  endtask : access
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    access(1'b1, a, d, 4'hF, rd);
  endtask : reg_wr
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] want);
    access(1'b0, a, 32'h00000000, 4'hF, rd);
    check(rd, want);
  endtask : rd_chk
  task automatic irq_chk(input logic [IRQ_W-1:0] st, input logic want);
    @(posedge clk);
    irq_status <= st;
    repeat (2) @(posedge clk);
    check({31'h0, irq}, {31'h0, want});
  endtask : irq_chk
  // ----
  // main sequence
  // ----
  initial
  begin
    srst = 1'b1;
    {read, write, address, byteenable, writedata, irq_status} = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd_chk(FRAME_NUMBER_ADDR, 32'h00000000);
    rd_chk(GLOBAL_DEVICE_STATE_ADDR, 32'h00000000);
    rd_chk(FUNCTION_ADDRESS_ADDR, 32'h00000100);
    rd_chk(IRQ_MASK_VIEW_ADDR, 32'h00001200);
    rd_chk(IRQ_ENABLE_SET_ADDR, 32'h00000000);
    reg_wr(32'hFFFA400C, 32'hFFFFFFFF);
    rd_chk(32'hFFFA400C, 32'h00000000);
    // top frame count, a lone pid, then a bad frame with a slow end of packet
    host.send_sof(11'h7FF, 1'b0, 0);
    rd_chk(FRAME_NUMBER_ADDR, 32'h000207FF);
    host.send_pid();
    rd_chk(FRAME_NUMBER_ADDR, 32'h000007FF);
    host.send_sof(11'h155, 1'b1, 5);
    rd_chk(FRAME_NUMBER_ADDR, 32'h00010155);
    // address loaded before the addressed bit, as software must
    reg_wr(FUNCTION_ADDRESS_ADDR, 32'hFFFFFFAA);
    rd_chk(FUNCTION_ADDRESS_ADDR, 32'h0000012A);
    reg_wr(GLOBAL_DEVICE_STATE_ADDR, 32'hFFFFFFFD);
    rd_chk(GLOBAL_DEVICE_STATE_ADDR, 32'h00000001);
    reg_wr(GLOBAL_DEVICE_STATE_ADDR, 32'h00000002);
    rd_chk(GLOBAL_DEVICE_STATE_ADDR, 32'h00000003);
    reg_wr(GLOBAL_DEVICE_STATE_ADDR, 32'h00000000);
    rd_chk(GLOBAL_DEVICE_STATE_ADDR, 32'h00000001);
    reg_wr(FUNCTION_ADDRESS_ADDR, 32'h0000007F);
    rd_chk(FUNCTION_ADDRESS_ADDR, 32'h0000007F);
    check({31'h0, function_enable_bit}, 32'h00000000);
    // every bit of the enable register, then of the disable register
    exp = 32'h00001200;
    for (b = 0; b < IRQ_W; b++)
    begin
      reg_wr(IRQ_ENABLE_SET_ADDR, 32'h1 << b);
      exp = exp | ((32'h1 << b) & {18'h0, MASK_WRITABLE});
      rd_chk(IRQ_MASK_VIEW_ADDR, exp);
    end
    for (b = 0; b < IRQ_W; b++)
    begin
      reg_wr(IRQ_ENABLE_CLEAR_ADDR, 32'h1 << b);
      exp = exp & ~((32'h1 << b) & {18'h0, MASK_WRITABLE});
      rd_chk(IRQ_MASK_VIEW_ADDR, exp);
    end
    rd_chk(IRQ_MASK_VIEW_ADDR, 32'h00001000);
    access(1'b1, IRQ_ENABLE_SET_ADDR, 32'hFFFFFFFF, 4'h1, rd);
    reg_wr(IRQ_MASK_VIEW_ADDR, 32'h00000000);
    rd_chk(IRQ_MASK_VIEW_ADDR, 32'h0000103F);
    irq_chk(14'h0100, 1'b0);
    irq_chk(14'h0101, 1'b1);
    irq_chk(14'h1000, 1'b1);
    host.bus_reset();
    rd_chk(IRQ_MASK_VIEW_ADDR, 32'h00001200);
    rd_chk(GLOBAL_DEVICE_STATE_ADDR, 32'h00000000);
    reg_wr(FUNCTION_ADDRESS_ADDR, 32'h0000017F);
    rd_chk(FUNCTION_ADDRESS_ADDR, 32'h0000017F);
    check({31'h0, function_enable_bit}, 32'h00000001);
    // second reset in mid-run
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd_chk(FUNCTION_ADDRESS_ADDR, 32'h00000100);
    print_verdict();
  end
endmodule : usb_device_state_and_irq_regs_tb
